/* sfspi_frontend.sv */
// Purpose: Pin front end of a serial flash: select, edges, lanes, hold, reset.
// Assumes: SCLK is the link clock; CONFIG changes only between frames.
// Notes:   Link logic runs on SCLK, user side on CLK; data crossings by toggles.
//
// Behaviour
// - Chip select high deselects and floats every driven data line.
// - Ignore instructions after power-up until chip select first rises.
// - Single mode captures opcode, address and write data on rising edges.
// - Single mode drives read data on the output pin at falling edges.
// - Dual and quad use shared lines: capture rising, drive falling.
// - Quad opcodes accepted only with quad enable; lines 2,3 become data.
// - Active-low write protect with status protect refuses status writes.
// - Write protect with protect bits locks the region configuration.
// - Quad enable disables the write protect function.
// - Hold low while selected floats output, ignores input and clock.
// - Hold release resumes exactly where the pause began.
// - Quad enable disables the hold function.
// - Without quad enable, line 3 is hold or reset per select bit.
// - Clock modes 0 and 3 both work.
// - Opcodes 3Bh and BBh use lines 0 and 1 bidirectionally.
// - Opcodes 6Bh, EBh, E7h use all four lines.
// - Protect, hold and reset functions absent during quad instructions.
// - Hold starts and ends at once if clock low, else next falling edge.
// - Hold/reset select defaults to hold; one gives active-low reset.
// - Reset pin low returns to power-on state; no commands meanwhile.
// - Quad enable is zero after reset so line 3 acts as hold.
module sfspi_frontend #(
  parameter int RESET_CYCLES = sfspi_pkg::RESET_MIN_CYCLES
) (
  // System clock and reset
  input  wire logic                        CLK,
  input  wire logic                        RST,
  // Configuration bits
  input  wire sfspi_pkg::sfspi_config_type CONFIG,
  // Read data supply
  input  wire logic [7:0]                  READ_DATA,
  input  wire logic                        READ_LOAD,
  // Received instructions
  output logic                             EVENT_VALID,
  output sfspi_pkg::sfspi_event_type       EVENT,
  // Status
  output logic                             SELECTED,
  output logic                             HW_LOCKED,
  output logic                             RESET_ACTIVE,
  output logic                             DEVICE_RESET,
  // Link pins
  input  wire logic                        SCLK,
  input  wire logic                        CS_N,
  input  wire logic [3:0]                  DATA_LINE_IN,
  output logic [3:0]                       DATA_LINE_OUT,
  output logic [3:0]                       DATA_LINE_OE
);

  if (RESET_CYCLES < 1 || RESET_CYCLES > 4095) begin : g_check
    $error("RESET_CYCLES out of range");
  end

  localparam int CW = $clog2(RESET_CYCLES + 1);

  // ****
  // Functions
  // ****
  function automatic logic [3:0] cycles_per_byte(
    input sfspi_pkg::sfspi_lanes_type l);
    unique case (l)
      sfspi_pkg::LANE_2: cycles_per_byte = 4'h4;
      sfspi_pkg::LANE_4: cycles_per_byte = 4'h2;
      default:           cycles_per_byte = 4'h8;
    endcase
  endfunction : cycles_per_byte

  function automatic logic [7:0] shift_in(input logic [7:0] s,
    input sfspi_pkg::sfspi_lanes_type l, input logic [3:0] p);
    unique case (l)
      sfspi_pkg::LANE_2: shift_in = {s[5:0], p[1:0]};
      sfspi_pkg::LANE_4: shift_in = {s[3:0], p};
      default:           shift_in = {s[6:0], p[0]};
    endcase
  endfunction : shift_in

  function automatic sfspi_pkg::sfspi_decode_type decode(
    input logic [7:0] op);
    sfspi_pkg::sfspi_decode_type d;
    d = '{1'b0, 1'b0, 1'b0, sfspi_pkg::LANE_1, sfspi_pkg::LANE_1, 4'h0};
    unique case (op)
      sfspi_pkg::OP_READ:      d = '{1'b1, 1'b1, 1'b0, sfspi_pkg::LANE_1,
        sfspi_pkg::LANE_1, 4'h0};
      sfspi_pkg::OP_FAST_READ: d = '{1'b1, 1'b1, 1'b0, sfspi_pkg::LANE_1,
        sfspi_pkg::LANE_1, sfspi_pkg::DUMMY_FAST};
      sfspi_pkg::OP_DUAL_OUT:  d = '{1'b1, 1'b1, 1'b0, sfspi_pkg::LANE_1,
        sfspi_pkg::LANE_2, sfspi_pkg::DUMMY_FAST};
      sfspi_pkg::OP_DUAL_IO:   d = '{1'b1, 1'b1, 1'b0, sfspi_pkg::LANE_2,
        sfspi_pkg::LANE_2, sfspi_pkg::DUMMY_DUAL_IO};
      sfspi_pkg::OP_QUAD_OUT:  d = '{1'b1, 1'b1, 1'b1, sfspi_pkg::LANE_1,
        sfspi_pkg::LANE_4, sfspi_pkg::DUMMY_FAST};
      sfspi_pkg::OP_QUAD_IO:   d = '{1'b1, 1'b1, 1'b1, sfspi_pkg::LANE_4,
        sfspi_pkg::LANE_4, sfspi_pkg::DUMMY_QUAD_IO};
      sfspi_pkg::OP_WORD_QIO:  d = '{1'b1, 1'b1, 1'b1, sfspi_pkg::LANE_4,
        sfspi_pkg::LANE_4, sfspi_pkg::DUMMY_WORD_QIO};
      sfspi_pkg::OP_RD_STATUS: d.is_out = 1'b1;
      default:                 d.is_out = 1'b0;
    endcase
    decode = d;
  endfunction : decode

  // ****
  // System domain
  // ****
  sfspi_pkg::sfspi_config_type cfg, next_cfg;
  logic [2:0]  cs_sync, next_cs_sync;
  logic [1:0]  wp_sync, next_wp_sync;
  logic [1:0]  rp_sync, next_rp_sync;
  logic [2:0]  rx_sync, next_rx_sync;
  logic [CW-1:0] low_cnt, next_low_cnt;
  logic [7:0]  tx_hold, next_tx_hold;
  logic        tx_tog, next_tx_tog;
  logic        next_event_valid, next_device_reset;
  sfspi_pkg::sfspi_event_type next_event;
  logic        rx_tog;
  sfspi_pkg::sfspi_event_type rx_hold;
  logic        pin_reset_mode;

  assign pin_reset_mode = cfg.hold_reset_select & ~cfg.quad_enable;

  always_comb begin
    next_cfg          = CONFIG;
    next_cs_sync      = {cs_sync[1:0], CS_N};
    next_wp_sync      = {wp_sync[0], DATA_LINE_IN[2]};
    next_rp_sync      = {rp_sync[0], DATA_LINE_IN[3]};
    next_rx_sync      = {rx_sync[1:0], rx_tog};
    next_tx_hold      = READ_LOAD ? READ_DATA : tx_hold;
    next_tx_tog       = tx_tog ^ READ_LOAD;
    next_low_cnt      = low_cnt;
    next_device_reset = 1'b0;
    if (pin_reset_mode && !rp_sync[1]) begin
      if (low_cnt != CW'(RESET_CYCLES)) begin
        next_low_cnt = low_cnt + CW'(1);
      end
      next_device_reset = (low_cnt == CW'(RESET_CYCLES - 1));
    end else begin
      next_low_cnt = '0;
    end
    next_event       = EVENT;
    next_event_valid = 1'b0;
    if (rx_sync[2] != rx_sync[1] && !RESET_ACTIVE) begin
      next_event       = rx_hold;
      next_event_valid = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg          <= '0;
      cfg.quad_enable       <= sfspi_pkg::QUAD_ENABLE_RESET;
      cfg.hold_reset_select <= sfspi_pkg::HOLD_RESET_SEL_RESET;
      cs_sync      <= 3'h7;
      wp_sync      <= 2'h3;
      rp_sync      <= 2'h3;
      rx_sync      <= 3'h0;
      low_cnt      <= '0;
      tx_hold      <= 8'h00;
      tx_tog       <= 1'b0;
      EVENT        <= '0;
      EVENT_VALID  <= 1'b0;
      DEVICE_RESET <= 1'b0;
    end else begin
      cfg          <= next_cfg;
      cs_sync      <= next_cs_sync;
      wp_sync      <= next_wp_sync;
      rp_sync      <= next_rp_sync;
      rx_sync      <= next_rx_sync;
      low_cnt      <= next_low_cnt;
      tx_hold      <= next_tx_hold;
      tx_tog       <= next_tx_tog;
      EVENT        <= next_event;
      EVENT_VALID  <= next_event_valid;
      DEVICE_RESET <= next_device_reset;
    end
  end

  assign SELECTED     = ~cs_sync[1];
  assign RESET_ACTIVE = pin_reset_mode & ~rp_sync[1];
  assign HW_LOCKED    = ~cfg.quad_enable & cfg.status_reg_protect
                        & ~wp_sync[1];

  // ****
  // Power-up arming and link reset
  // ****
  logic armed, link_rst;

  always_ff @(posedge CS_N or posedge RST) begin
    if (RST) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  // Pin reset overrides all inputs
  assign link_rst = RST | CS_N | ~armed
                    | (pin_reset_mode & ~DATA_LINE_IN[3]);

  // ****
  // Link domain: crossings
  // ****
  sfspi_pkg::sfspi_config_type cfg_s1, cfg_s2;
  logic [1:0] txt_sync;
  logic       tx_seen, next_tx_seen, next_rx_tog;
  logic [7:0] tx_byte, next_tx_byte;
  logic       emit;
  sfspi_pkg::sfspi_event_type ev, next_rx_hold;

  always_comb begin
    next_tx_seen = txt_sync[1];
    next_tx_byte = (txt_sync[1] != tx_seen) ? tx_hold : tx_byte;
    next_rx_tog  = rx_tog ^ emit;
    next_rx_hold = emit ? ev : rx_hold;
  end

  always_ff @(posedge SCLK or posedge RST) begin
    if (RST) begin
      cfg_s1   <= '0;
      cfg_s2   <= '0;
      txt_sync <= 2'h0;
      tx_seen  <= 1'b0;
      tx_byte  <= 8'h00;
      rx_tog   <= 1'b0;
      rx_hold  <= '0;
    end else begin
      cfg_s1   <= cfg;
      cfg_s2   <= cfg_s1;
      txt_sync <= {txt_sync[0], tx_tog};
      tx_seen  <= next_tx_seen;
      tx_byte  <= next_tx_byte;
      rx_tog   <= next_rx_tog;
      rx_hold  <= next_rx_hold;
    end
  end

  // ****
  // Link domain: input sequencer
  // ****
  sfspi_pkg::sfspi_state_type  state, next_state;
  sfspi_pkg::sfspi_decode_type dec, next_dec;
  sfspi_pkg::sfspi_lanes_type  lanes, next_lanes;
  logic [3:0]  cnt, next_cnt;
  logic [7:0]  shreg, next_shreg, opcode, next_opcode, sh;
  logic [23:0] addr, next_addr;
  logic [1:0]  bidx, next_bidx;
  logic        hold_rise, hold_fn, hold_eff, wp_lock, byte_done;

  assign hold_fn  = ~cfg_s2.quad_enable & ~cfg_s2.hold_reset_select
                    & ~(dec.is_quad & state != sfspi_pkg::ST_OPCODE);
  assign hold_eff = hold_fn & ~CS_N
                    & (SCLK ? hold_rise : ~DATA_LINE_IN[3]);
  assign wp_lock  = ~cfg_s2.quad_enable & cfg_s2.status_reg_protect
                    & ~DATA_LINE_IN[2];
  assign sh        = shift_in(shreg, lanes, DATA_LINE_IN);
  assign byte_done = (cnt == cycles_per_byte(lanes) - 4'h1);

  always_comb begin
    next_state  = state;
    next_dec    = dec;
    next_lanes  = lanes;
    next_cnt    = cnt;
    next_shreg  = shreg;
    next_opcode = opcode;
    next_addr   = addr;
    next_bidx   = bidx;
    emit        = 1'b0;
    ev          = '{sfspi_pkg::EV_CMD, opcode, addr, sh};
    if (!hold_eff) begin
      unique case (state)
        sfspi_pkg::ST_OPCODE, sfspi_pkg::ST_ADDR,
        sfspi_pkg::ST_DATA_IN: begin
          next_shreg = sh;
          next_cnt   = byte_done ? 4'h0 : cnt + 4'h1;
          if (byte_done && state == sfspi_pkg::ST_OPCODE) begin
            next_opcode = sh;
            next_dec    = decode(sh);
            next_lanes  = next_dec.addr_lanes;
            next_bidx   = 2'h0;
            ev.opcode   = sh;
            if (next_dec.is_quad && !cfg_s2.quad_enable) begin
              next_state = sfspi_pkg::ST_IGNORE;
            end else if (sh == sfspi_pkg::OP_WR_STATUS && wp_lock) begin
              next_state = sfspi_pkg::ST_IGNORE;
              ev.kind    = sfspi_pkg::EV_REFUSED;
              emit       = 1'b1;
            end else if (next_dec.has_addr) begin
              next_state = sfspi_pkg::ST_ADDR;
            end else begin
              next_state = next_dec.is_out ? sfspi_pkg::ST_DATA_OUT
                                           : sfspi_pkg::ST_DATA_IN;
              next_lanes = sfspi_pkg::LANE_1;
              emit       = 1'b1;
            end
          end else if (byte_done && state == sfspi_pkg::ST_ADDR) begin
            next_addr = {addr[15:0], sh};
            next_bidx = bidx + 2'h1;
            if (bidx == sfspi_pkg::ADDR_LAST_BYTE) begin
              ev.addr    = next_addr;
              emit       = 1'b1;
              next_lanes = dec.data_lanes;
              next_state = (dec.dummy != 4'h0) ? sfspi_pkg::ST_DUMMY
                                               : sfspi_pkg::ST_DATA_OUT;
            end
          end else if (byte_done) begin
            ev.kind = sfspi_pkg::EV_DATA;
            emit    = 1'b1;
          end
        end
        sfspi_pkg::ST_DUMMY: begin
          next_cnt = cnt + 4'h1;
          if (cnt == dec.dummy - 4'h1) begin
            next_cnt   = 4'h0;
            next_state = sfspi_pkg::ST_DATA_OUT;
          end
        end
        sfspi_pkg::ST_DATA_OUT, sfspi_pkg::ST_IGNORE: begin
          next_state = state;
        end
        default: next_state = sfspi_pkg::ST_IGNORE;
      endcase
    end
  end

  always_ff @(posedge SCLK or posedge link_rst) begin
    if (link_rst) begin
      state     <= sfspi_pkg::ST_OPCODE;
      dec       <= '0;
      lanes     <= sfspi_pkg::LANE_1;
      cnt       <= 4'h0;
      shreg     <= 8'h00;
      opcode    <= 8'h00;
      addr      <= 24'h00_0000;
      bidx      <= 2'h0;
      hold_rise <= 1'b0;
    end else begin
      state     <= next_state;
      dec       <= next_dec;
      lanes     <= next_lanes;
      cnt       <= next_cnt;
      shreg     <= next_shreg;
      opcode    <= next_opcode;
      addr      <= next_addr;
      bidx      <= next_bidx;
      hold_rise <= ~DATA_LINE_IN[3];
    end
  end

  // ****
  // Link domain: output driver on falling edges
  // ****
  logic [7:0] oshreg, next_oshreg, ob;
  logic [3:0] ocnt, next_ocnt, dout, next_dout, doe, next_doe;

  always_comb begin
    next_oshreg = oshreg;
    next_ocnt   = ocnt;
    next_dout   = dout;
    next_doe    = doe;
    ob          = (ocnt == 4'h0) ? tx_byte : oshreg;
    if (state == sfspi_pkg::ST_DATA_OUT && !hold_eff) begin
      next_ocnt = (ocnt == cycles_per_byte(lanes) - 4'h1) ? 4'h0
                                                        : ocnt + 4'h1;
      unique case (lanes)
        sfspi_pkg::LANE_2: begin
          next_dout   = {2'b00, ob[7:6]};
          next_oshreg = {ob[5:0], 2'b00};
          next_doe    = 4'h3;
        end
        sfspi_pkg::LANE_4: begin
          next_dout   = ob[7:4];
          next_oshreg = {ob[3:0], 4'h0};
          next_doe    = 4'hF;
        end
        default: begin
          next_dout   = {2'b00, ob[7], 1'b0};
          next_oshreg = {ob[6:0], 1'b0};
          next_doe    = 4'h2;
        end
      endcase
    end else if (state != sfspi_pkg::ST_DATA_OUT) begin
      next_doe = 4'h0;
    end
  end

  always_ff @(negedge SCLK or posedge link_rst) begin
    if (link_rst) begin
      oshreg <= 8'h00;
      ocnt   <= 4'h0;
      dout   <= 4'h0;
      doe    <= 4'h0;
    end else begin
      oshreg <= next_oshreg;
      ocnt   <= next_ocnt;
      dout   <= next_dout;
      doe    <= next_doe;
    end
  end

  assign DATA_LINE_OUT = dout;
  assign DATA_LINE_OE  = doe & {4{~hold_eff & ~link_rst}};

endmodule : sfspi_frontend

/* sfspi_frontend_assertions.sv */
// Purpose: Port checks of the serial flash pin front end.
// Assumes: CONFIG only changes between frames.
// Notes:   Bound to every sfspi_frontend instance.
module sfspi_frontend_assertions #(
  parameter int RESET_CYCLES = 2
) (
  // Clock and reset
  input wire logic                        CLK,
  input wire logic                        RST,
  // Configuration and status
  input wire sfspi_pkg::sfspi_config_type CONFIG,
  input wire logic                        EVENT_VALID,
  input wire logic                        HW_LOCKED,
  input wire logic                        RESET_ACTIVE,
  input wire logic                        DEVICE_RESET,
  // Link pins
  input wire logic                        SCLK,
  input wire logic                        CS_N,
  input wire logic [3:0]                  DATA_LINE_IN,
  input wire logic [3:0]                  DATA_LINE_OE
);
  logic [7:0] low_cnt, next_low_cnt;

  // Consecutive cycles with line 3 low
  always_comb begin
    next_low_cnt = low_cnt;
    if (DATA_LINE_IN[3]) begin
      next_low_cnt = 8'h00;
    end else if (low_cnt != 8'hff) begin
      next_low_cnt = low_cnt + 8'h01;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= next_low_cnt;
    end
  end

  // ****
  // Properties
  // ****
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_hold_cfg;
    (!CONFIG.quad_enable && !CONFIG.hold_reset_select) [*6];
  endsequence
  sequence s_quad_cfg;
    CONFIG.quad_enable [*6];
  endsequence

  property p_deselect_float;
    CS_N |-> DATA_LINE_OE == 4'h0;
  endproperty
  a_deselect_float: assert property (p_deselect_float)
    else $error("OE deselected");

  property p_hold_float;
    s_hold_cfg ##0 (!CS_N && !SCLK && !DATA_LINE_IN[3])
      |-> DATA_LINE_OE == 4'h0;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("OE in hold");

  property p_quad_no_lock;
    s_quad_cfg |-> !HW_LOCKED;
  endproperty
  a_quad_no_lock: assert property (p_quad_no_lock)
    else $error("lock in quad");

  property p_lock_set;
    (CONFIG.status_reg_protect && !CONFIG.quad_enable
      && !DATA_LINE_IN[2]) [*6] |-> HW_LOCKED;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("lock missing");

  property p_lock_needs_pin;
    DATA_LINE_IN[2] [*6] |-> !HW_LOCKED;
  endproperty
  a_lock_needs_pin: assert property (p_lock_needs_pin)
    else $error("lock with pin high");

  property p_reset_level;
    (CONFIG.hold_reset_select && !CONFIG.quad_enable
      && !DATA_LINE_IN[3]) [*6] |-> RESET_ACTIVE;
  endproperty
  a_reset_level: assert property (p_reset_level)
    else $error("reset missing");

  property p_no_reset_fn;
    (CONFIG.quad_enable || !CONFIG.hold_reset_select) [*6]
      |-> !RESET_ACTIVE;
  endproperty
  a_no_reset_fn: assert property (p_no_reset_fn)
    else $error("reset unexpected");

  property p_quiet_reset;
    RESET_ACTIVE |-> !EVENT_VALID;
  endproperty
  a_quiet_reset: assert property (p_quiet_reset)
    else $error("event in reset");

  property p_reset_pulse;
    DEVICE_RESET |-> (low_cnt >= RESET_CYCLES) ##1 !DEVICE_RESET;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("reset pulse bad");
endmodule : sfspi_frontend_assertions

bind sfspi_frontend sfspi_frontend_assertions #(
  .RESET_CYCLES(RESET_CYCLES)
) chk (
  .CLK         (CLK),
  .RST         (RST),
  .CONFIG      (CONFIG),
  .EVENT_VALID (EVENT_VALID),
  .HW_LOCKED   (HW_LOCKED),
  .RESET_ACTIVE(RESET_ACTIVE),
  .DEVICE_RESET(DEVICE_RESET),
  .SCLK        (SCLK),
  .CS_N        (CS_N),
  .DATA_LINE_IN(DATA_LINE_IN),
  .DATA_LINE_OE(DATA_LINE_OE)
);

/* sfspi_host_model.sv */
// Purpose: Host that drives the flash link pins in mode 0 or 3.
// Assumes: SCLK of 32 ns runs only inside frames.
// Notes:   Lines 2 and 3 rest at their pull-up level.
module sfspi_host_model (
  // Link pins
  output logic            SCLK,
  output logic            CS_N,
  output logic [3:0]      DATA_LINE_IN,
  // Device drive
  input  wire logic [3:0] DATA_LINE_OUT,
  input  wire logic [3:0] DATA_LINE_OE
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       cpol   = 1'b0;
  logic       wp_n   = 1'b1;
  logic       hold_n = 1'b1;
  logic [3:0] drv    = 4'h0;
  logic [3:0] hv     = 4'h0;
  logic [3:0] pull;

  // Select low from power-up, before any arming edge
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b0;
  end
  // Released lines 0,1 show a changed level
  assign pull = {hold_n, wp_n, ~hv[1:0]};
  assign DATA_LINE_IN = (DATA_LINE_OE & DATA_LINE_OUT)
                      | (~DATA_LINE_OE & drv & hv)
                      | (~DATA_LINE_OE & ~drv & pull);

  task automatic clk1(input logic [3:0] v, input logic [3:0] en);
    SCLK = 1'b0;
    drv = en;
    hv = v;
    #16;
    SCLK = 1'b1;
    #16;
  endtask : clk1

  task automatic frame_on();
    SCLK = cpol;
    #16;
    CS_N = 1'b0;
    #16;
  endtask : frame_on

  task automatic frame_off();
    SCLK = cpol;
    drv = 4'h0;
    #16;
    CS_N = 1'b1;
    #48;
  endtask : frame_off

  task automatic send(input logic [31:0] val, input int n, input int w);
    logic [31:0] s;
    s = val << (32 - n);
    repeat (n / w) begin
      clk1(4'(s[31:28] >> (4 - w)), 4'((1 << w) - 1));
      s = s << w;
    end
  endtask : send

  task automatic idle(input int n);
    repeat (n) clk1(4'h0, 4'h0);
  endtask : idle

  task automatic recv(input int w, output logic [7:0] b);
    logic [3:0] m;
    b = 8'h00;
    repeat (8 / w) begin
      SCLK = 1'b0;
      drv = 4'h0;
      #16;
      m = (w == 1) ? {3'h0, DATA_LINE_IN[1]} : DATA_LINE_IN;
      b = (b << w) | 8'(m & 4'((1 << w) - 1));
      SCLK = 1'b1;
      #16;
    end
  endtask : recv

  // Pause with the clock low, then clock noise
  task automatic hold_on(input int n);
    SCLK = 1'b0;
    #16;
    hold_n = 1'b0;
    #16;
    repeat (n) clk1(4'h1, 4'h1);
    SCLK = 1'b0;
    #16;
  endtask : hold_on

  task automatic hold_off();
    hold_n = 1'b1;
    #16;
  endtask : hold_off
endmodule : sfspi_host_model

/* sfspi_pkg.sv */
// Purpose: Shared constants and types of the serial flash pin front end.
// Assumes: Opcodes and phase lengths are those of the supported reads.
// Notes:   Config bits arrive as plain ports, not registers.
package sfspi_pkg;

  // ****
  // Opcodes
  // ****
  localparam logic [7:0] OP_READ      = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT  = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO   = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT  = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO   = 8'hEB;
  localparam logic [7:0] OP_WORD_QIO  = 8'hE7;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;

  // ****
  // Phase lengths and timing
  // ****
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [3:0] DUMMY_FAST     = 4'h8;
  localparam logic [3:0] DUMMY_DUAL_IO  = 4'h4;
  localparam logic [3:0] DUMMY_QUAD_IO  = 4'h6;
  localparam logic [3:0] DUMMY_WORD_QIO = 4'h4;
  localparam int RESET_MIN_NS      = 1000;
  localparam int CLK_PERIOD_NS     = 50;
  localparam int RESET_MIN_CYCLES  =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****
  // Reset values
  // ****
  localparam logic QUAD_ENABLE_RESET    = 1'b0;
  localparam logic HOLD_RESET_SEL_RESET = 1'b0;

  // ****
  // Types
  // ****
  typedef enum logic [5:0] {
    ST_OPCODE   = 6'h01,
    ST_ADDR     = 6'h02,
    ST_DUMMY    = 6'h04,
    ST_DATA_IN  = 6'h08,
    ST_DATA_OUT = 6'h10,
    ST_IGNORE   = 6'h20
  } sfspi_state_type;

  typedef enum logic [1:0] {
    LANE_1 = 2'h0,
    LANE_2 = 2'h1,
    LANE_4 = 2'h2
  } sfspi_lanes_type;

  typedef enum logic [1:0] {
    EV_CMD     = 2'h0,
    EV_DATA    = 2'h1,
    EV_REFUSED = 2'h2
  } sfspi_event_kind_type;

  typedef struct packed {
    logic       quad_enable;
    logic       hold_reset_select;
    logic       status_reg_protect;
    logic       complement_protect;
    logic       sector_granularity;
    logic       top_bottom_select;
    logic [2:0] block_protect;
  } sfspi_config_type;

  typedef struct packed {
    sfspi_event_kind_type kind;
    logic [7:0]           opcode;
    logic [23:0]          addr;
    logic [7:0]           data;
  } sfspi_event_type;

  typedef struct packed {
    logic            has_addr;
    logic            is_out;
    logic            is_quad;
    sfspi_lanes_type addr_lanes;
    sfspi_lanes_type data_lanes;
    logic [3:0]      dummy;
  } sfspi_decode_type;

endpackage : sfspi_pkg

/* test_serial_flash_spi_pin_frontend.sv */
// Purpose: Self-checking bench of the serial flash pin front end.
// Assumes: Host model clocks the link at 32 ns inside frames.
// Notes:   RESET_CYCLES cut to 2 to keep the run short.
module test_serial_flash_spi_pin_frontend;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK, RST, READ_LOAD, EVENT_VALID, SELECTED, HW_LOCKED;
  logic RESET_ACTIVE, DEVICE_RESET, SCLK, CS_N;
  logic [7:0] READ_DATA;
  logic [3:0] DATA_LINE_IN, DATA_LINE_OUT, DATA_LINE_OE;
  sfspi_pkg::sfspi_config_type CONFIG;
  sfspi_pkg::sfspi_event_type  EVENT, ev_q;
  int error_cnt = 0, total_checks = 0;
  int ev_cnt = 0, rst_cnt = 0, cyc = 0;
  localparam logic [7:0] OPS [8] = '{8'h03, 8'h0b, 8'h3b, 8'hbb,
                                     8'h6b, 8'heb, 8'he7, 8'h05};
  localparam int AW [8] = '{1, 1, 1, 2, 1, 4, 4, 1};
  localparam int DM [8] = '{0, 8, 8, 4, 8, 6, 4, 0};
  localparam int DW [8] = '{1, 1, 2, 2, 4, 4, 4, 1};

  sfspi_frontend #(.RESET_CYCLES(2)) uut (
    .CLK(CLK), .RST(RST), .CONFIG(CONFIG), .READ_DATA(READ_DATA),
    .READ_LOAD(READ_LOAD), .EVENT_VALID(EVENT_VALID), .EVENT(EVENT),
    .SELECTED(SELECTED), .HW_LOCKED(HW_LOCKED),
    .RESET_ACTIVE(RESET_ACTIVE), .DEVICE_RESET(DEVICE_RESET),
    .SCLK(SCLK), .CS_N(CS_N), .DATA_LINE_IN(DATA_LINE_IN),
    .DATA_LINE_OUT(DATA_LINE_OUT), .DATA_LINE_OE(DATA_LINE_OE));
  sfspi_host_model host (
    .SCLK(SCLK), .CS_N(CS_N), .DATA_LINE_IN(DATA_LINE_IN),
    .DATA_LINE_OUT(DATA_LINE_OUT), .DATA_LINE_OE(DATA_LINE_OE));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // Event capture and run limit
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (EVENT_VALID) begin
      ev_q <= EVENT;
      ev_cnt <= ev_cnt + 1;
    end
    if (DEVICE_RESET) rst_cnt <= rst_cnt + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cfg(input logic q, input logic h, input logic p);
    @(posedge CLK);
    CONFIG <= '{q, h, p, 1'b0, 1'b0, 1'b0, 3'h0};
    repeat (6) @(posedge CLK);
  endtask : cfg

  task automatic frame(input logic [7:0] op, input logic [23:0] a);
    host.frame_on();
    host.send({24'h0, op}, 8, 1);
    host.send({8'h00, a}, 24, 1);
    host.idle(8);
    check(DATA_LINE_OE, 4'h0);
    host.frame_off();
    repeat (8) @(posedge CLK);
  endtask : frame

  task automatic rd(input int i, input logic [23:0] a, input logic [7:0] b);
    logic [7:0] got;
    int         n0;
    n0 = ev_cnt;
    @(posedge CLK);
    READ_DATA <= b;
    READ_LOAD <= 1'b1;
    @(posedge CLK);
    READ_LOAD <= 1'b0;
    host.frame_on();
    host.send({24'h0, OPS[i]}, 8, 1);
    host.send({8'h00, a}, (i == 7) ? 0 : 24, AW[i]);
    host.idle(DM[i]);
    host.recv(DW[i], got);
    host.frame_off();
    repeat (8) @(posedge CLK);
    check(ev_cnt - n0, 1);
    check(ev_q.opcode, OPS[i]);
    if (i != 7) check(ev_q.addr, a);
    check(got, b);
    check(DATA_LINE_OE, 4'h0);
  endtask : rd

  task automatic t_power_up();
    host.send(32'h03, 8, 1);
    host.send(32'h40, 24, 1);
    host.frame_off();
    repeat (8) @(posedge CLK);
    check(ev_cnt, 0);
    $display("t_power_up done");
  endtask : t_power_up

  task automatic t_reads();
    for (int i = 0; i < 8; i++) begin
      if (i == 4) cfg(1'b1, 1'b0, 1'b0);
      if (i == 7) host.cpol = 1'b1;
      rd(i, 24'(24'h5a_3c00 + i * 16), 8'(8'h96 + i * 17));
    end
    host.cpol = 1'b0;
    cfg(1'b0, 1'b0, 1'b0);
    $display("t_reads done");
  endtask : t_reads

  task automatic t_refuse();
    int n0;
    n0 = ev_cnt;
    frame(8'h6b, 24'h00_1000);
    check(ev_cnt - n0, 0);
    $display("t_refuse done");
  endtask : t_refuse

  task automatic t_hold();
    logic [7:0] got;
    rd(0, 24'h12_3456, 8'hc5);
    host.frame_on();
    host.send(32'h03, 8, 1);
    host.send(32'h12_3456, 24, 1);
    host.hold_on(3);
    check(DATA_LINE_OE, 4'h0);
    check(SELECTED, 1);
    host.hold_off();
    host.recv(1, got);
    host.frame_off();
    check(got, 8'hc5);
    $display("t_hold done");
  endtask : t_hold

  task automatic t_protect();
    cfg(1'b0, 1'b0, 1'b1);
    host.wp_n = 1'b0;
    repeat (8) @(posedge CLK);
    check(HW_LOCKED, 1);
    host.frame_on();
    host.send(32'h01, 8, 1);
    host.send(32'h02, 8, 1);
    host.frame_off();
    repeat (8) @(posedge CLK);
    check(ev_q.kind, sfspi_pkg::EV_REFUSED);
    cfg(1'b1, 1'b0, 1'b1);
    check(HW_LOCKED, 0);
    host.wp_n = 1'b1;
    cfg(1'b0, 1'b0, 1'b0);
    $display("t_protect done");
  endtask : t_protect

  task automatic t_reset_pin();
    int n0;
    n0 = rst_cnt;
    cfg(1'b0, 1'b1, 1'b0);
    host.hold_n = 1'b0;
    repeat (24) @(posedge CLK);
    check(RESET_ACTIVE, 1);
    check(rst_cnt - n0, 1);
    n0 = ev_cnt;
    frame(8'h03, 24'h00_0100);
    check(ev_cnt - n0, 0);
    host.hold_n = 1'b1;
    cfg(1'b0, 1'b0, 1'b0);
    check(RESET_ACTIVE, 0);
    $display("t_reset_pin done");
  endtask : t_reset_pin

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  initial begin
    RST = 1'b1;
    CONFIG = '0;
    READ_DATA = 8'h00;
    READ_LOAD = 1'b0;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    t_power_up();
    t_reads();
    t_refuse();
    t_hold();
    t_protect();
    t_reset_pin();
    conclude();
  end
endmodule : test_serial_flash_spi_pin_frontend
